// file: hdl/dmd_decoder.sv
/*
  dmd_decoder: internal data memory and special function register decoder.
  Assumes: the CPU presents one request per cycle on req_i with req_valid_i;
  peripheral sfrs live outside and answer on ext_sfr_* in the same cycle.
*/
`timescale 1ns/10ps
module dmd_decoder #(
  parameter logic LARGE_PROG = 1'b1
) (
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 req_valid_i,
  input  wire dmd_pkg::dmd_req_type req_i,
  input  wire logic                 parity_i,
  input  wire logic [7:0]           ext_sfr_rdata_i,
  input  wire logic                 ext_sfr_hit_i,
  input  wire logic [7:0]           code_rdata_i,
  output dmd_pkg::dmd_rsp_type      rsp_o,
  output logic                      ext_sfr_we_o,
  output logic [7:0]                ext_sfr_addr_o,
  output logic [7:0]                ext_sfr_wdata_o,
  output logic [7:0]                sp_o,
  output logic [1:0]                bank_o
);
  import dmd_pkg::*;

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] idx);
    bank_addr = {3'b000, bank, idx};
  endfunction

  function automatic logic bit_capable_sfr(input logic [7:0] a);
    bit_capable_sfr = (a[2:0] == 3'b000);
  endfunction

  // ****************************************************************
  // internal signals
  // ****************************************************************
  logic [7:0] program_status_word;
  logic [7:0] program_store_control;
  logic [7:0] sp;
  logic [1:0] bank;
  logic [7:0] ram_raddr;
  logic [7:0] ram_rdata;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic       ram_we;
  logic [7:0] ptr_addr;
  logic [7:0] ptr_val;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic       sfr_we;
  logic       sfr_sel;
  logic [7:0] sfr_rdata;
  logic [7:0] sfr_ext_masked;
  logic       own_sfr;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  logic       bit_in_sfr;
  logic [7:0] byte_rd;
  logic [7:0] byte_wr;
  logic       do_req;
  logic       sp_inc;
  logic       sp_dec;
  logic       is_data;
  logic [7:0] rdata_nxt;
  logic       rbit_nxt;

  assign do_req = req_valid_i && rst_n_r;
  assign bank   = {program_status_word[DMD_PSW_BANK_HI_POS], program_status_word[DMD_PSW_BANK_LO_POS]};
  assign is_data = (req_i.op != DMD_OP_CODE) && !req_i.xmove;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // indirect pointer first read out of the active bank
  assign ptr_addr = bank_addr(bank, {2'b00, req_i.addr[0]});

  // bit address mapping: low half in ram, high half in bit-capable sfrs
  assign bit_in_sfr = req_i.addr[7];
  assign bit_pos    = req_i.addr[2:0];
  assign bit_byte   = bit_in_sfr ? {req_i.addr[7:3], 3'b000}
                                 : DMD_BIT_BYTE_BASE + {4'h0, req_i.addr[6:3]};

  always_comb begin
    sfr_sel   = 1'b0;
    sfr_addr  = req_i.addr[7:0];
    ram_raddr = req_i.addr[7:0];
    case (req_i.op)
      DMD_OP_DIRECT: begin
        sfr_sel   = req_i.addr[7];
        ram_raddr = req_i.addr[7:0];
      end
      DMD_OP_INDIRECT: begin
        sfr_sel   = 1'b0;
        ram_raddr = ptr_addr;
      end
      DMD_OP_REG: begin
        ram_raddr = bank_addr(bank, req_i.addr[2:0]);
      end
      DMD_OP_BIT: begin
        sfr_sel   = bit_in_sfr && bit_capable_sfr(bit_byte);
        sfr_addr  = bit_byte;
        ram_raddr = bit_byte;
      end
      DMD_OP_PUSH: begin
        ram_raddr = sp + 8'h01;
      end
      DMD_OP_POP: begin
        ram_raddr = sp;
      end
      default: begin
        sfr_sel   = 1'b0;
      end
    endcase
  end

  // the indirect access needs the pointer value and then the target; the
  // pointer comes from a second combinational look so one cycle suffices
  logic [7:0] ptr_rdata;
  dmd_ram u_ptr_ram_shadow_unused_guard_free (
    .clk_i   (clk_i),
    .we_i    (1'b0),
    .waddr_i (8'h00),
    .wdata_i (8'h00),
    .raddr_i (8'h00),
    .rdata_o ()
  );
  assign ptr_rdata = 8'h00;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0] ram_mem_r [256];
  logic [7:0] ind_target;

  assign ptr_val    = ram_mem_r[ptr_addr];
  assign ind_target = ptr_val;
  assign ram_rdata  = (req_i.op == DMD_OP_INDIRECT) ? ram_mem_r[ind_target]
                                                    : ram_mem_r[ram_raddr];

  always_comb begin
    ram_waddr = (req_i.op == DMD_OP_INDIRECT) ? ind_target : ram_raddr;
    ram_we    = do_req && is_data && !sfr_sel && (req_i.op != DMD_OP_NONE)
                && (req_i.wr || req_i.op == DMD_OP_PUSH) && (req_i.op != DMD_OP_POP)
                && !(req_i.op == DMD_OP_DIRECT && req_i.addr[7]);
  end

  always_ff @(posedge clk_i) begin
    if (ram_we) begin
      ram_mem_r[ram_waddr] <= ram_wdata;
    end
  end

  // ****************************************************************
  // sfr space
  // ****************************************************************
  assign own_sfr = (sfr_addr == DMD_SP_ADDR) || (sfr_addr == DMD_PSW_ADDR)
                   || (sfr_addr == DMD_PROGRAM_STORE_CONTROL_ADDR);
  assign sfr_ext_masked = ext_sfr_hit_i ? ext_sfr_rdata_i : 8'h00;

  assign byte_rd = sfr_sel ? sfr_rdata : ram_rdata;

  // bit writes keep the other seven bits of the addressed byte
  always_comb begin
    byte_wr = req_i.wdata;
    if (req_i.op == DMD_OP_BIT) begin
      byte_wr          = byte_rd;
      byte_wr[bit_pos] = req_i.wbit;
    end
  end

  assign ram_wdata = byte_wr;
  assign sfr_wdata = byte_wr;
  assign sfr_we    = do_req && sfr_sel && req_i.wr && is_data;

  // only occupied external sfrs see writes
  assign ext_sfr_we_o    = sfr_we && !own_sfr && ext_sfr_hit_i;
  assign ext_sfr_addr_o  = sfr_addr;
  assign ext_sfr_wdata_o = sfr_wdata;

  assign sp_inc = do_req && req_i.op == DMD_OP_PUSH;
  assign sp_dec = do_req && req_i.op == DMD_OP_POP;

  dmd_sfr u_sfr (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_r),
    .we_i        (sfr_we),
    .addr_i      (sfr_addr),
    .wdata_i     (sfr_wdata),
    .sp_inc_i    (sp_inc),
    .sp_dec_i    (sp_dec),
    .parity_i    (parity_i),
    .ext_rdata_i (sfr_ext_masked),
    .rdata_o     (sfr_rdata),
    .sp_o        (sp),
    .psw_o       (program_status_word),
    .program_store_control_o     (program_store_control)
  );

  // ****************************************************************
  // answer
  // ****************************************************************
  always_comb begin
    rdata_nxt = (req_i.op == DMD_OP_CODE || req_i.xmove) ? code_rdata_i : byte_rd;
    rbit_nxt  = byte_rd[bit_pos];
  end

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid         <= do_req && !req_i.wr;
      rsp_o.rdata         <= rdata_nxt;
      rsp_o.rbit          <= (req_i.op == DMD_OP_BIT) ? rbit_nxt : 1'b0;
      rsp_o.prog_wr       <= do_req && req_i.xmove && req_i.wr
                             && program_store_control[DMD_PROGRAM_STORE_CONTROL_WREN_POS];
      rsp_o.prog_addr     <= req_i.addr;
      rsp_o.prog_reserved <= do_req && !is_data && LARGE_PROG
                             && (req_i.addr > DMD_PROG_TOP_LARGE);
    end
  end

  assign sp_o   = sp;
  assign bank_o = bank;

endmodule // dmd_decoder

// file: hdl/dmd_pkg.sv
/*
  dmd_pkg: constants and carrier types for the data memory and special function
  register decoder.
  Assumes: a single core clock domain; the CPU execution logic is the only user.
*/
package dmd_pkg;

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam logic [7:0]  DMD_SFR_BASE       = 8'h80;
  localparam logic [7:0]  DMD_BIT_BYTE_BASE  = 8'h20;
  localparam logic [7:0]  DMD_SP_ADDR        = 8'h81;
  localparam logic [7:0]  DMD_PSW_ADDR       = 8'hD0;
  localparam logic [7:0]  DMD_PROGRAM_STORE_CONTROL_ADDR     = 8'h8F;
  localparam logic [15:0] DMD_PROG_TOP_LARGE = 16'hFBFF;

  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int DMD_PSW_BANK_LO_POS  = 3;
  localparam int DMD_PSW_BANK_HI_POS  = 4;
  localparam int DMD_PSW_PARITY_POS   = 0;
  localparam int DMD_PROGRAM_STORE_CONTROL_WREN_POS   = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] DMD_SP_RESET    = 8'h07;
  localparam logic [7:0] DMD_PSW_RESET   = 8'h00;
  localparam logic [7:0] DMD_PROGRAM_STORE_CONTROL_RESET = 8'h00;

  // ****************************************************************
  // access kinds
  // ****************************************************************
  typedef enum logic [2:0] {
    DMD_OP_NONE     = 3'b000,
    DMD_OP_DIRECT   = 3'b001,
    DMD_OP_INDIRECT = 3'b010,
    DMD_OP_REG      = 3'b011,
    DMD_OP_BIT      = 3'b100,
    DMD_OP_PUSH     = 3'b101,
    DMD_OP_POP      = 3'b110,
    DMD_OP_CODE     = 3'b111
  } dmd_op_type;

  typedef struct packed {
    dmd_op_type  op;
    logic        wr;
    logic        xmove;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wbit;
  } dmd_req_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
    logic        rbit;
    logic        prog_wr;
    logic [15:0] prog_addr;
    logic        prog_reserved;
  } dmd_rsp_type;

endpackage : dmd_pkg

// file: hdl/dmd_ram.sv
/*
  dmd_ram: 256 x 8 internal data RAM, one read and one write port.
  Assumes: synchronous write, combinational read, same clock as the decoder.
*/
`timescale 1ns/10ps
module dmd_ram #(
  parameter int DEPTH = 256
) (
  input  wire logic       clk_i,
  input  wire logic       we_i,
  input  wire logic [7:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] raddr_i,
  output logic      [7:0] rdata_o
);
  import dmd_pkg::*;

  logic [7:0] mem_r [DEPTH];

  // no reset: ram contents are undefined at power up, as in real silicon
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_r[raddr_i];

endmodule // dmd_ram

// file: hdl/dmd_sfr.sv
/*
  dmd_sfr: the special function registers this block owns (stack pointer,
  status word, program store control) and the read select between them and the external sfrs.
  Assumes: writes arrive already decoded to sfr space by the top module.
*/
`timescale 1ns/10ps
module dmd_sfr (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       we_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       sp_inc_i,
  input  wire logic       sp_dec_i,
  input  wire logic       parity_i,
  input  wire logic [7:0] ext_rdata_i,
  output logic      [7:0] rdata_o,
  output logic      [7:0] sp_o,
  output logic      [7:0] psw_o,
  output logic      [7:0] program_store_control_o
);
  import dmd_pkg::*;

  logic [7:0] sp_r;
  logic [7:0] psw_r;
  logic [7:0] program_store_control_r;

  // ****************************************************************
  // stack pointer
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_r <= DMD_SP_RESET;
    end else if (we_i && addr_i == DMD_SP_ADDR) begin
      sp_r <= wdata_i;
    end else if (sp_inc_i) begin
      sp_r <= sp_r + 8'h01;
    end else if (sp_dec_i) begin
      sp_r <= sp_r - 8'h01;
    end
  end

  // ****************************************************************
  // status word and program store control
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psw_r <= DMD_PSW_RESET;
    end else if (we_i && addr_i == DMD_PSW_ADDR) begin
      psw_r <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      program_store_control_r <= DMD_PROGRAM_STORE_CONTROL_RESET;
    end else if (we_i && addr_i == DMD_PROGRAM_STORE_CONTROL_ADDR) begin
      program_store_control_r <= wdata_i;
    end
  end

  // parity is read-only: supplied by the core, the written bit is stored but never shown
  always_comb begin
    psw_o                     = psw_r;
    psw_o[DMD_PSW_PARITY_POS] = parity_i;
  end

  assign sp_o    = sp_r;
  assign program_store_control_o = program_store_control_r;

  always_comb begin
    case (addr_i)
      DMD_SP_ADDR:    rdata_o = sp_r;
      DMD_PSW_ADDR:   rdata_o = psw_o;
      DMD_PROGRAM_STORE_CONTROL_ADDR: rdata_o = program_store_control_r;
      default:        rdata_o = ext_rdata_i;
    endcase
  end

endmodule // dmd_sfr

// file: test/dmd_decoder_assertions.sv
/* dmd_chk: port-level checks of dmd_decoder.
   Assumes: bound to dmd_decoder, one clock, raw reset as disable. */
`timescale 1ns/10ps
module dmd_chk
  import dmd_pkg::*;
#(
  parameter logic LARGE_PROG = 1'b1
) (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        req_valid_i,
  input wire dmd_req_type req_i,
  input wire logic        parity_i,
  input wire logic [7:0]  ext_sfr_rdata_i,
  input wire logic        ext_sfr_hit_i,
  input wire logic [7:0]  code_rdata_i,
  input wire dmd_rsp_type rsp_o,
  input wire logic        ext_sfr_we_o,
  input wire logic [7:0]  ext_sfr_addr_o,
  input wire logic [7:0]  ext_sfr_wdata_o,
  input wire logic [7:0]  sp_o,
  input wire logic [1:0]  bank_o
);
  // ****************************************
  // helpers
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic       own_w;
  logic       dwr_w;
  logic [1:0] wbank_w;
  assign own_w   = req_i.addr[7:0] inside {DMD_SP_ADDR, DMD_PSW_ADDR, DMD_PROGRAM_STORE_CONTROL_ADDR};
  assign dwr_w   = req_valid_i && req_i.op == DMD_OP_DIRECT && req_i.wr;
  assign wbank_w = req_i.wdata[4:3];
  // ****************************************
  // properties
  // ****************************************
  a_push_sp_up: assert property (
    req_valid_i && req_i.op == DMD_OP_PUSH |=> sp_o == $past(sp_o) + 8'h01)
    else $error("push did not raise sp");
  a_pop_sp_down: assert property (
    req_valid_i && req_i.op == DMD_OP_POP |=> sp_o == $past(sp_o) - 8'h01)
    else $error("pop did not lower sp");
  a_sp_steady: assert property (
    !(req_valid_i && req_i.op inside {DMD_OP_PUSH, DMD_OP_POP})
    && !(dwr_w && req_i.addr[7:0] == DMD_SP_ADDR) |=> $stable(sp_o))
    else $error("sp moved without cause");
  a_bank_set: assert property (
    dwr_w && req_i.addr[7:0] == DMD_PSW_ADDR |=> bank_o == $past(wbank_w))
    else $error("bank does not follow status word");
  a_sfr_write: assert property (
    dwr_w && req_i.addr[7] && !own_w && ext_sfr_hit_i
    |-> ext_sfr_we_o && ext_sfr_addr_o == req_i.addr[7:0])
    else $error("direct upper write missed sfr");
  a_indirect_ram: assert property (
    req_valid_i && req_i.op == DMD_OP_INDIRECT |-> !ext_sfr_we_o)
    else $error("indirect access reached sfr");
  a_unused_zero: assert property (
    req_valid_i && req_i.op == DMD_OP_DIRECT && !req_i.wr && req_i.addr[7]
    && !own_w && !ext_sfr_hit_i |=> rsp_o.rdata == 8'h00)
    else $error("unoccupied sfr read not zero");
  a_prog_gate: assert property (
    !(req_valid_i && req_i.wr && req_i.xmove) |=> !rsp_o.prog_wr)
    else $error("program write without external move");
  a_reserved_top: assert property (
    req_valid_i && req_i.op == DMD_OP_CODE
    |=> rsp_o.prog_reserved == (LARGE_PROG && $past(req_i.addr) > DMD_PROG_TOP_LARGE))
    else $error("reserved flag wrong");
endmodule // dmd_chk

bind dmd_decoder dmd_chk #(.LARGE_PROG(LARGE_PROG)) u_chk (
  .clk_i, .arst_n_i, .req_valid_i, .req_i, .parity_i, .ext_sfr_rdata_i,
  .ext_sfr_hit_i, .code_rdata_i, .rsp_o, .ext_sfr_we_o, .ext_sfr_addr_o,
  .ext_sfr_wdata_o, .sp_o, .bank_o
);

// file: test/dmd_far_model.sv
/* dmd_far_model: peripheral sfrs at 0x88 (bit capable) and 0x82, and
   program memory contents. Assumes: same clock as the decoder. */
`timescale 1ns/10ps
module dmd_far_model (
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [15:0] code_addr_i,
  output logic      [7:0]  rdata_o,
  output logic             hit_o,
  output logic      [7:0]  code_o
);
  // ****************************************
  // peripheral registers
  // ****************************************
  logic [7:0] port_r;
  logic [7:0] ptr_r;
  always_ff @(posedge clk_i) begin
    if (we_i && addr_i == 8'h88) port_r <= wdata_i;
    if (we_i && addr_i == 8'h82) ptr_r <= wdata_i;
  end
  // every other address is left unoccupied
  assign hit_o = (addr_i == 8'h88) || (addr_i == 8'h82);
  // a miss shows junk, so a decoder that forwards it is caught
  assign rdata_o = (addr_i == 8'h88) ? port_r : (addr_i == 8'h82) ? ptr_r : ~addr_i;
  assign code_o = code_addr_i[7:0] ^ code_addr_i[15:8] ^ 8'h5A;
endmodule // dmd_far_model

// file: test/testbench.sv
/* testbench: directed checks of dmd_decoder through its request port.
   Assumes: dmd_far_model answers peripheral sfrs and program memory. */
`timescale 1ns/10ps
module testbench;
  import dmd_pkg::*;
  logic        clk;
  logic        arst_n;
  logic        req_valid;
  dmd_req_type req;
  logic        parity;
  logic [7:0]  sfr_rdata;
  logic        sfr_hit;
  logic [7:0]  code_rdata;
  dmd_rsp_type rsp;
  logic        sfr_we;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sp;
  logic [1:0]  bank;
  dmd_rsp_type got;
  logic        got_we;
  int          n_errors;
  int          comparisons;

  dmd_decoder uut (.clk_i(clk), .arst_n_i(arst_n), .req_valid_i(req_valid), .req_i(req),
    .parity_i(parity), .ext_sfr_rdata_i(sfr_rdata), .ext_sfr_hit_i(sfr_hit),
    .code_rdata_i(code_rdata), .rsp_o(rsp), .ext_sfr_we_o(sfr_we),
    .ext_sfr_addr_o(sfr_addr), .ext_sfr_wdata_o(sfr_wdata), .sp_o(sp), .bank_o(bank));
  dmd_far_model u_far (.clk_i(clk), .we_i(sfr_we), .addr_i(sfr_addr), .wdata_i(sfr_wdata),
    .code_addr_i(req.addr), .rdata_o(sfr_rdata), .hit_o(sfr_hit), .code_o(code_rdata));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] act);
    comparisons++;
    if (act !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, act);
    end
  endtask
  // one request, held to its taking edge; answer read mid next cycle
  task automatic acc(input dmd_op_type op, input logic w, input logic xm,
                     input logic [15:0] a, input logic [7:0] d, input logic b);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op, w, xm, a, d, b};
    @(negedge clk);
    got_we = sfr_we;
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    got = rsp;
  endtask
  task automatic wr(input dmd_op_type op, input logic [15:0] a, input logic [7:0] d);
    acc(op, 1'b1, 1'b0, a, d, 1'b0);
  endtask
  task automatic rd(input string what, input dmd_op_type op, input logic [15:0] a,
                    input logic [7:0] e);
    acc(op, 1'b0, 1'b0, a, 8'h00, 1'b0);
    chk(what, {8'h00, e}, {8'h00, got.rdata});
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    finish_test;
  end

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    parity = 1'b0;
    n_errors = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("sp", 16'h0007, {8'h00, sp});
    rd("sp read", DMD_OP_DIRECT, 16'h0081, 8'h07);
    wr(DMD_OP_PUSH, 16'h0000, 8'hC3);
    chk("sp", 16'h0008, {8'h00, sp});
    wr(DMD_OP_DIRECT, 16'h00D0, 8'h08);
    rd("bank1 r0", DMD_OP_REG, 16'h0000, 8'hC3);
    tend("reset_stack");
    for (int n = 0; n < 4; n++) begin
      wr(DMD_OP_DIRECT, 16'h00D0, {3'h0, 2'(n), 3'h0});
      chk("bank", {14'h0, 2'(n)}, {14'h0, bank});
      wr(DMD_OP_REG, 16'h0007, {6'h10, 2'(n)});
      rd("bank r7", DMD_OP_DIRECT, {11'h0, 2'(n), 3'h7}, {6'h10, 2'(n)});
    end
    parity <= 1'b1;
    rd("status", DMD_OP_DIRECT, 16'h00D0, 8'h19);
    tend("banks");
    wr(DMD_OP_REG, 16'h0000, 8'h90);
    wr(DMD_OP_REG, 16'h0001, 8'h30);
    wr(DMD_OP_INDIRECT, 16'h0000, 8'h5A);
    rd("upper ram", DMD_OP_INDIRECT, 16'h0000, 8'h5A);
    rd("sfr 90", DMD_OP_DIRECT, 16'h0090, 8'h00);
    wr(DMD_OP_DIRECT, 16'h0030, 8'h11);
    rd("via r1", DMD_OP_INDIRECT, 16'h0001, 8'h11);
    tend("indirect");
    wr(DMD_OP_DIRECT, 16'h0022, 8'h41);
    acc(DMD_OP_BIT, 1'b1, 1'b0, 16'h0013, 8'h00, 1'b1);
    rd("bit byte", DMD_OP_DIRECT, 16'h0022, 8'h49);
    acc(DMD_OP_BIT, 1'b0, 1'b0, 16'h0013, 8'h00, 1'b0);
    chk("rbit", 16'h0001, {15'h0, got.rbit});
    wr(DMD_OP_DIRECT, 16'h0088, 8'h00);
    chk("sfr we", 16'h0001, {15'h0, got_we});
    acc(DMD_OP_BIT, 1'b1, 1'b0, 16'h008A, 8'h00, 1'b1);
    rd("sfr bit", DMD_OP_DIRECT, 16'h0088, 8'h04);
    // deliberate touch of an unoccupied slot
    wr(DMD_OP_DIRECT, 16'h009B, 8'h77);
    rd("unused sfr", DMD_OP_DIRECT, 16'h009B, 8'h00);
    tend("bits_sfr");
    acc(DMD_OP_NONE, 1'b1, 1'b1, 16'h1234, 8'hAB, 1'b0);
    chk("prog wr off", 16'h0000, {15'h0, got.prog_wr});
    wr(DMD_OP_DIRECT, 16'h008F, 8'h01);
    acc(DMD_OP_NONE, 1'b1, 1'b1, 16'h1234, 8'hAB, 1'b0);
    chk("prog wr on", 16'h0001, {15'h0, got.prog_wr});
    chk("prog addr", 16'h1234, got.prog_addr);
    wr(DMD_OP_DIRECT, 16'h008F, 8'h00);
    rd("code 30", DMD_OP_CODE, 16'h0030, 8'h6A);
    chk("reserved", 16'h0000, {15'h0, got.prog_reserved});
    rd("code FBFF", DMD_OP_CODE, 16'hFBFF, 8'h5E);
    chk("reserved", 16'h0000, {15'h0, got.prog_reserved});
    rd("code FC00", DMD_OP_CODE, 16'hFC00, 8'hA6);
    chk("reserved", 16'h0001, {15'h0, got.prog_reserved});
    tend("program");
    wr(DMD_OP_DIRECT, 16'h0081, 8'hFF);
    wr(DMD_OP_PUSH, 16'h0000, 8'h77);
    chk("sp wrap", 16'h0000, {8'h00, sp});
    wr(DMD_OP_DIRECT, 16'h00D0, 8'h00);
    rd("wrapped slot", DMD_OP_REG, 16'h0000, 8'h77);
    rd("pop", DMD_OP_POP, 16'h0000, 8'h77);
    chk("sp back", 16'h00FF, {8'h00, sp});
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("sp rereset", 16'h0007, {8'h00, sp});
    chk("bank rereset", 16'h0000, {14'h0, bank});
    tend("stack_wrap");
    finish_test;
  end
endmodule // testbench
